// *** rtl/flp_cfg.svh ***
`ifndef FLP_CFG_SVH
`define FLP_CFG_SVH

// ==========================================================
// Widths
`define FLP_CNT_W 16
`define FLP_CFG_W 7
`define FLP_PREDIV_W 4
`define FLP_SRC_DIV_W 8

// ==========================================================
// Configuration word layout
`define FLP_CFG_CLK_SEL_BIT 1
`define FLP_CFG_PREDIV_MSB 6
`define FLP_CFG_PREDIV_LSB 3
`define FLP_SEL_SLOW 1'b1

// ==========================================================
// Reset values
`define FLP_ON_TIME_RST 16'h0000
`define FLP_OFF_TIME_RST 16'hffff
`define FLP_PREDIV_RST 4'h0
`define FLP_CNT_RST 16'h0000

// ==========================================================
// Timing
`define FLP_CORE_CLK_HZ 20000000
`define FLP_SLOW_CLK_HZ 100000
`define FLP_FAST_CLK_HZ 48000000
`define FLP_SLOW_CYC (`FLP_CORE_CLK_HZ / `FLP_SLOW_CLK_HZ)
`define FLP_FAST_CYC ((`FLP_CORE_CLK_HZ / `FLP_FAST_CLK_HZ) < 1 ? 1 : \
  (`FLP_CORE_CLK_HZ / `FLP_FAST_CLK_HZ))

`endif

// *** rtl/flp_pkg.sv ***
`include "flp_cfg.svh"

package flp_pkg;

  // ==========================================================
  // Scalar types
  typedef logic [`FLP_CNT_W-1:0] flp_count_t;
  typedef logic [`FLP_CFG_W-1:0] flp_cfg_t;
  typedef logic [`FLP_PREDIV_W-1:0] flp_prediv_t;
  typedef logic [`FLP_SRC_DIV_W-1:0] flp_srcdiv_t;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_FULL_ON = 2'b01,
    MODE_FULL_OFF = 2'b10
  } flp_mode_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_ON = 3'b001,
    ST_OFF = 3'b010,
    ST_FULL_ON = 3'b011,
    ST_FULL_OFF = 3'b100,
    ST_SLEEP = 3'b101
  } flp_state_t;

  // ==========================================================
  // Module state records
  typedef struct packed {
    flp_state_t state;
    logic out;
    logic asleep;
    flp_count_t cnt;
    flp_count_t off_lat;
  } flp_ctl_t;

  typedef struct packed {
    flp_srcdiv_t slow_cnt;
    flp_srcdiv_t fast_cnt;
  } flp_src_t;

  typedef struct packed {
    flp_prediv_t pcnt;
  } flp_div_t;

endpackage

// *** rtl/flp_tick_if.sv ***
`timescale 1ns/100ps
`include "flp_cfg.svh"

interface flp_tick_if;
  logic run;
  logic clk_sel;
  logic [`FLP_PREDIV_W-1:0] pre_div;
  logic slow_tick;
  logic fast_tick;
  logic count_tick;

  modport src (input run, output slow_tick, output fast_tick);
  modport div (input run, input clk_sel, input pre_div, input slow_tick,
    input fast_tick, output count_tick);
  modport ctl (output run, output clk_sel, output pre_div, input count_tick);
endinterface

// *** rtl/flp_tick_src.sv ***
`timescale 1ns/100ps
`include "flp_cfg.svh"

module flp_tick_src (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  flp_tick_if.src bus // Source ticks out, run in
);
  import flp_pkg::*;

  localparam flp_srcdiv_t SLOW_LAST = flp_srcdiv_t'(`FLP_SLOW_CYC - 1);
  localparam flp_srcdiv_t FAST_LAST = flp_srcdiv_t'(`FLP_FAST_CYC - 1);

  flp_src_t r;
  flp_src_t next_r;

  function automatic flp_srcdiv_t div_next(input flp_srcdiv_t cnt, input flp_srcdiv_t last);
    div_next = (cnt == last) ? '0 : flp_srcdiv_t'(cnt + 8'h01);
  endfunction

  // ==========================================================
  // Reference rates as enables
  // The fast source cannot run above the core rate; it saturates at one tick per cycle
  assign bus.slow_tick = bus.run && (r.slow_cnt == SLOW_LAST);
  assign bus.fast_tick = bus.run && (r.fast_cnt == FAST_LAST);

  always_comb begin
    next_r = r;
    if (!bus.run) begin
      next_r.slow_cnt = '0;
      next_r.fast_cnt = '0;
    end else begin
      next_r.slow_cnt = div_next(r.slow_cnt, SLOW_LAST);
      next_r.fast_cnt = div_next(r.fast_cnt, FAST_LAST);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// *** rtl/flp_prediv.sv ***
`timescale 1ns/100ps
`include "flp_cfg.svh"

module flp_prediv (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  flp_tick_if.div bus // Source ticks in, count tick out
);
  import flp_pkg::*;

  flp_div_t r;
  flp_div_t next_r;
  logic src_tick;
  logic wrap;

  // ==========================================================
  // Source select and divide by pre_div plus one
  assign src_tick = (bus.clk_sel == `FLP_SEL_SLOW) ? bus.slow_tick : bus.fast_tick;
  // Compare with >= so a lowered divider never strands the counter above it
  assign wrap = (r.pcnt >= bus.pre_div);
  assign bus.count_tick = bus.run && src_tick && wrap;

  always_comb begin
    next_r = r;
    if (!bus.run) begin
      next_r.pcnt = '0;
    end else if (src_tick) begin
      next_r.pcnt = wrap ? '0 : flp_prediv_t'(r.pcnt + 4'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r.pcnt <= `FLP_PREDIV_RST;
    end else begin
      r <= next_r;
    end
  end
endmodule

// *** rtl/flp_pwm.sv ***
`timescale 1ns/100ps
`include "flp_cfg.svh"


module flp_pwm (
  input wire logic core_clk, // Core clock, 20 MHz
  input wire logic rst, // Synchronous system reset, active high
  input wire flp_pkg::flp_count_t on_time, // High interval in count ticks
  input wire flp_pkg::flp_count_t off_time, // Low interval in count ticks
  input wire flp_pkg::flp_cfg_t pwm_config, // Clock select and pre-divider
  input wire logic sleep_request, // Sleep request from power_clock_reset_unit
  output logic pwm_output, // Modulated output
  output logic pwm_asleep, // Block is in sleep
  output flp_pkg::flp_count_t pwm_counter // Ticks left in current phase
);
  import flp_pkg::*;

  // ==========================================================
  // Tick generation
  flp_tick_if tick_bus ();
  flp_ctl_t r;
  flp_ctl_t next_r;
  flp_mode_t live_mode;

  // Dividers stop and clear whenever sleep is asked for, without waiting a cycle
  assign tick_bus.run = !sleep_request && (r.state != ST_SLEEP);
  assign tick_bus.clk_sel = pwm_config[`FLP_CFG_CLK_SEL_BIT];
  assign tick_bus.pre_div = pwm_config[`FLP_CFG_PREDIV_MSB:`FLP_CFG_PREDIV_LSB];

  flp_tick_src u_src (
    .core_clk(core_clk),
    .rst(rst),
    .bus(tick_bus.src)
  );

  flp_prediv u_div (
    .core_clk(core_clk),
    .rst(rst),
    .bus(tick_bus.div)
  );

  // ==========================================================
  // Mode decode and period start
  function automatic flp_mode_t mode_of(input flp_count_t on_c, input flp_count_t off_c);
    if (off_c == '0) begin
      mode_of = MODE_FULL_ON;
    end else if (on_c == '0) begin
      mode_of = MODE_FULL_OFF;
    end else begin
      mode_of = MODE_TOGGLE;
    end
  endfunction

  // Phase ends on the tick that would take the count to zero
  function automatic logic phase_end(input flp_count_t c);
    phase_end = (c <= 16'h0001);
  endfunction

  function automatic flp_count_t count_down(input flp_count_t c);
    count_down = flp_count_t'(c - 16'h0001);
  endfunction

  // Counts are latched only here, so a half-written pair never splits a period
  function automatic flp_ctl_t begin_period(input flp_count_t on_c, input flp_count_t off_c);
    flp_ctl_t s;
    s.asleep = 1'b0;
    s.off_lat = off_c;
    unique case (mode_of(on_c, off_c))
      MODE_FULL_ON: begin
        s.state = ST_FULL_ON;
        s.out = 1'b1;
        s.cnt = '0;
      end
      MODE_FULL_OFF: begin
        s.state = ST_FULL_OFF;
        s.out = 1'b0;
        s.cnt = '0;
      end
      default: begin
        s.state = ST_ON;
        s.out = 1'b1;
        s.cnt = on_c;
      end
    endcase
    begin_period = s;
  endfunction

  // ==========================================================
  // Waveform state machine
  always_comb begin
    next_r = r;
    live_mode = mode_of(on_time, off_time);
    if (sleep_request) begin
      next_r.state = ST_SLEEP;
      next_r.asleep = 1'b1;
      next_r.out = 1'b0;
      next_r.cnt = `FLP_CNT_RST;
      next_r.off_lat = `FLP_CNT_RST;
    end else begin
      unique case (r.state)
        ST_LOAD, ST_SLEEP, ST_FULL_ON, ST_FULL_OFF: begin
          next_r = begin_period(on_time, off_time);
        end
        ST_ON: begin
          if (live_mode != MODE_TOGGLE) begin
            next_r = begin_period(on_time, off_time);
          end else if (tick_bus.count_tick) begin
            if (phase_end(r.cnt)) begin
              next_r.state = ST_OFF;
              next_r.out = 1'b0;
              next_r.cnt = r.off_lat;
            end else begin
              next_r.cnt = count_down(r.cnt);
            end
          end
        end
        ST_OFF: begin
          if (live_mode != MODE_TOGGLE) begin
            next_r = begin_period(on_time, off_time);
          end else if (tick_bus.count_tick) begin
            if (phase_end(r.cnt)) begin
              next_r = begin_period(on_time, off_time);
            end else begin
              next_r.cnt = count_down(r.cnt);
            end
          end
        end
        default: begin
          next_r = begin_period(on_time, off_time);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r.state <= ST_LOAD;
      r.out <= 1'b0;
      r.asleep <= 1'b0;
      r.cnt <= `FLP_CNT_RST;
      r.off_lat <= `FLP_OFF_TIME_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  // No event output exists; firmware polls the status ports if it needs them
  assign pwm_output = r.out;
  assign pwm_asleep = r.asleep;
  assign pwm_counter = r.cnt;
endmodule

// *** test/flp_pwm_asserts.sv ***
`timescale 1ns/100ps
module flp_pwm_asserts (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Reset
  input wire flp_pkg::flp_count_t on_time, // High count
  input wire flp_pkg::flp_count_t off_time, // Low count
  input wire flp_pkg::flp_cfg_t pwm_config, // Config
  input wire logic sleep_request, // Sleep request
  input wire logic pwm_output, // Pin
  input wire logic pwm_asleep, // Sleep flag
  input wire flp_pkg::flp_count_t pwm_counter // Phase count
);
  import flp_pkg::*;
  logic toggling;
  assign toggling = on_time != 16'h0000 && off_time != 16'h0000 && !sleep_request;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Steps
  sequence s_fast_run;
    toggling && !pwm_config[1] && pwm_config[6:3] == 4'h0 && pwm_counter > 16'h0001;
  endsequence
  sequence s_slow_tick;
    // Slow select must already stand at the deciding edge, else a fast step slips in
    toggling && pwm_config[1] && $past(pwm_config[1]) &&
      pwm_counter == $past(pwm_counter) - 16'h0001;
  endsequence
  // ==========================================================
  // Properties
  a_sleep_entry: assert property (sleep_request |=> pwm_asleep && !pwm_output &&
    pwm_counter == 16'h0000) else $error("sleep entry wrong");
  a_sleep_exit: assert property (pwm_asleep && !sleep_request |=> !pwm_asleep)
    else $error("sleep exit late");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !pwm_output && !pwm_asleep &&
    pwm_counter == 16'h0000) else $error("reset state wrong");
  a_full_on: assert property (off_time == 16'h0000 && !sleep_request |=> pwm_output &&
    pwm_counter == 16'h0000) else $error("full on wrong");
  a_full_off: assert property (on_time == 16'h0000 && off_time != 16'h0000 && !sleep_request
    |=> !pwm_output && pwm_counter == 16'h0000) else $error("full off wrong");
  a_load_on: assert property ($rose(pwm_output) && $past(on_time) != 16'h0000 &&
    $past(off_time) != 16'h0000 |-> pwm_counter == $past(on_time)) else $error("on load wrong");
  a_fast_step: assert property (s_fast_run |=> pwm_counter == $past(pwm_counter) - 16'h0001)
    else $error("fast count rate wrong");
  a_slow_hold: assert property (s_slow_tick |=> ($stable(pwm_counter) || !toggling ||
    !pwm_config[1]) [*8]) else $error("slow count too fast");
endmodule

bind flp_pwm flp_pwm_asserts flp_pwm_asserts_i (.core_clk(core_clk), .rst(rst),
  .on_time(on_time), .off_time(off_time), .pwm_config(pwm_config),
  .sleep_request(sleep_request), .pwm_output(pwm_output), .pwm_asleep(pwm_asleep),
  .pwm_counter(pwm_counter));

// *** test/flp_load_model.sv ***
`timescale 1ns/100ps
// Load on the pin: reports each whole level interval seen while armed
module flp_load_model (
  input wire logic core_clk, // Core clock
  input wire logic pin, // Driven pin
  input wire logic armed, // Measure enable
  output logic done, // Interval finished
  output logic level, // Level of that interval
  output logic [31:0] width // Its length in cycles
);
  logic last = 1'b0;
  logic seen = 1'b0;
  logic [31:0] run = 32'h0;
  // Partial interval at arming is never reported
  always @(posedge core_clk) begin
    done <= 1'b0;
    run <= run + 1;
    if (!armed) seen <= 1'b0;
    if (pin !== last) begin
      if (seen && armed) begin
        done <= 1'b1;
        level <= last;
        width <= run;
      end
      seen <= armed;
      run <= 32'h1;
    end
    last <= pin;
  end
endmodule

// *** test/flp_pwm_bench.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flp_pwm_bench;
  import flp_pkg::*;
  logic core_clk, rst, sleep_request, armed, done, level, pwm_output, pwm_asleep;
  flp_count_t on_time, off_time, pwm_counter;
  flp_cfg_t pwm_config;
  logic [31:0] width;
  logic [63:0] notes[$];
  logic [63:0] note;
  int error_cnt = 0;
  int num_checks = 0;
  flp_pwm flp_pwm_i (.core_clk(core_clk), .rst(rst), .on_time(on_time), .off_time(off_time),
    .pwm_config(pwm_config), .sleep_request(sleep_request), .pwm_output(pwm_output),
    .pwm_asleep(pwm_asleep), .pwm_counter(pwm_counter));
  flp_load_model flp_load_model_i (.core_clk(core_clk), .pin(pwm_output), .armed(armed),
    .done(done), .level(level), .width(width));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ==========================================================
  // Program, wait out an old period at the new rate, then note four intervals
  task automatic run_case(input flp_count_t on, input flp_count_t off, input flp_cfg_t cfg);
    int unsigned tk;
    int n;
    tk = (cfg[1] ? 200 : 1) * (cfg[6:3] + 1);
    on_time <= on;
    off_time <= off;
    pwm_config <= cfg;
    // Old period may still hold up to 16 counts, now ticking at this rate
    cyc((2 * (on + off) + 18) * tk + 4);
    armed <= 1'b1;
    repeat (4) notes.push_back({32'(on * tk), 32'(off * tk)});
    n = 0;
    while (notes.size() > 0 && n < 4 * (on + off) * tk + 10) begin
      cyc(1);
      n++;
    end
    armed <= 1'b0;
    `CHK(notes.size(), 0)
  endtask
  always @(posedge core_clk) begin
    if (done && notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(width, level ? note[63:32] : note[31:0])
    end
  end
  initial begin
    rst = 1'b1;
    {sleep_request, armed, on_time, pwm_config} = '0;
    off_time = 16'hffff;
    void'($urandom(9946));
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    `CHK(pwm_output, 1'b0)
    // Slow select stays clear: random slow periods would run too long
    for (int i = 0; i < 6; i++) begin
      run_case(16'($urandom_range(1, 8)), 16'($urandom_range(1, 8)),
        7'($urandom_range(0, 127)) & 7'h7d);
    end
    run_case(16'h0002, 16'h0001, 7'h02);
    run_case(16'h0001, 16'h0003, 7'h00);
    off_time <= 16'h0000;
    cyc(3);
    `CHK({pwm_output, pwm_counter}, 17'h10000)
    on_time <= 16'h0000;
    cyc(3);
    `CHK({pwm_output, pwm_counter}, 17'h10000)
    off_time <= 16'h0005;
    cyc(3);
    `CHK({pwm_output, pwm_counter}, 17'h00000)
    on_time <= 16'h0003;
    off_time <= 16'h0002;
    cyc(10);
    sleep_request <= 1'b1;
    cyc(3);
    `CHK({pwm_asleep, pwm_output, pwm_counter}, 18'h20000)
    sleep_request <= 1'b0;
    cyc(2);
    `CHK(pwm_asleep, 1'b0)
    cyc(5);
    rst <= 1'b1;
    cyc(3);
    `CHK({pwm_asleep, pwm_output, pwm_counter}, 18'h00000)
    rst <= 1'b0;
    run_case(16'h0002, 16'h0002, 7'h08);
    print_verdict();
  end
  initial begin
    cyc(40000);
    error_cnt++;
    print_verdict();
  end
endmodule
